// ### tkmc_pkg.sv
/*
 * Shared constants, key positions and state carriers of the front-panel
 * key matrix controller.
 * Assumes a single 200 MHz clock; all slow timing derives from a 1 ms tick.
 */
package tkmc_pkg;

    // clock and tick
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_MS = 1;

    // times in ms and their counts in ticks
    localparam int ENTRY_TIMEOUT_MS = 3500;
    localparam int FINE_HOLD_MS = 500;
    localparam int FINE_REPEAT_MS = 125;
    localparam int LEVEL_REPEAT_MS = 100;
    localparam int CHANNEL_PAUSE_MS = 600;
    localparam int SEARCH_WAIT_MS = 100;
    localparam int SKIP_SETTLE_MS = 2;
    localparam int AUTO_STEP_MS = 8;
    localparam int ENTRY_CNT = ENTRY_TIMEOUT_MS / TICK_MS;
    localparam int FINE_HOLD_CNT = FINE_HOLD_MS / TICK_MS;
    localparam int FINE_REPEAT_CNT = FINE_REPEAT_MS / TICK_MS;
    localparam int LEVEL_REPEAT_CNT = LEVEL_REPEAT_MS / TICK_MS;
    localparam int PAUSE_CNT = CHANNEL_PAUSE_MS / TICK_MS;
    localparam int SEARCH_CNT = SEARCH_WAIT_MS / TICK_MS;
    localparam int SETTLE_CNT = SKIP_SETTLE_MS / TICK_MS;
    localparam int AUTO_CNT = AUTO_STEP_MS / TICK_MS;

    // matrix geometry: bit index = row * 4 + (3 - return input)
    localparam logic [3:0] LAST_ROW = 4'h8;
    localparam int KEY_BITS = 36;
    localparam int KEY_FINE_UP = 10;
    localparam int KEY_FINE_DOWN = 11;
    localparam int KEY_CH_UP = 12;
    localparam int KEY_LOUD_UP = 13;
    localparam int KEY_CHROMA_UP = 14;
    localparam int KEY_HUE_UP = 15;
    localparam int KEY_CH_DOWN = 16;
    localparam int KEY_LOUD_DOWN = 17;
    localparam int KEY_CHROMA_DOWN = 18;
    localparam int KEY_HUE_DOWN = 19;
    localparam int KEY_SKIP_ERASE = 20;
    localparam int KEY_SKIP_WRITE = 21;
    localparam int KEY_AUDIO_MUX = 22;
    localparam int KEY_POWER = 23;
    localparam int SW_CABLE = 24;
    localparam int SW_AUTO_TUNE = 25;
    localparam int SW_CH_LOCK = 26;
    localparam int SW_MEM_EDIT = 27;
    localparam int DIODE_CH_COUNT = 28;
    localparam int DIODE_UPDOWN = 29;

    // channel plan and levels
    localparam logic [6:0] CH_MIN = 7'h02;
    localparam logic [6:0] CH_BROADCAST_MAX = 7'h53;
    localparam logic [6:0] CH_CABLE_105_MAX = 7'h24;
    localparam logic [6:0] CH_CABLE_133_MAX = 7'h40;
    localparam logic [6:0] FINE_UPPER = 7'h37;
    localparam logic [6:0] FINE_LOWER = 7'h49;
    localparam logic [5:0] LEVEL_INIT = 6'h20;
    localparam logic [5:0] LEVEL_MAX = 6'h3f;
    localparam logic [6:0] PWM_PERIOD = 7'h43;
    localparam logic [6:0] PWM_OFFSET = 7'h02;
    localparam logic [1:0] MUX_INIT = 2'h3;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_SKIP = 2'b01,
        CH_SEARCH = 2'b10,
        CH_PAUSE = 2'b11
    } tkmc_ch_e;

    typedef struct packed {
        logic [5:0] loudness;
        logic [5:0] chroma;
        logic [5:0] hue;
    } tkmc_levels_s;

    typedef struct packed {
        logic [17:0] tick_cnt;
        logic [3:0] row;
        logic [35:0] raw;
        logic [35:0] prev;
        logic [35:0] deb;
        logic [3:0] ret_s1, ret_s2;
        logic sd_s1, sd_s2, sk_s1, sk_s2;
        logic au_s1, au_s2, ad_s1, ad_s2;
        logic power, mute, pic_mute, blank;
        logic [6:0] channel;
        logic [6:0] fine;
        tkmc_levels_s lvl;
        logic [1:0] mux;
        logic pending;
        logic [3:0] tens;
        logic [11:0] entry_tmr;
        logic [9:0] rep_tmr;
        tkmc_ch_e ch_st;
        logic ch_up;
        logic [9:0] ch_tmr;
        logic [3:0] auto_tmr;
        logic skip_we, skip_bit;
        logic [6:0] pwm_cnt;
        logic pwm_loud, pwm_chroma, pwm_hue;
        logic [6:0] row_drive;
        logic [1:0] digit_drive;
    } tkmc_state_s;

endpackage

// ### tkmc_key_matrix.sv
/*
 * Front-panel key matrix controller: scans the segment/digit rows,
 * debounces keys, switches and diodes and turns them into channel,
 * fine tuning, level, skip-memory, audio multiplex and power actions.
 * Assumes return inputs, station detect, skip data and auto-tune
 * correction inputs are asynchronous pins; skip memory is addressed
 * externally by channel_num.
 */
`timescale 1ns/10ps

// Contract
// [RL1] two digit presses give tens then units
// [RL2] second digit missing 3-4 s abandons entry
// [RL3] nonexistent channel entry discarded, old channel kept
// [RL4] short fine-up press adds one step
// [RL5] held fine-up repeats every 125 ms
// [RL6] fine offset wraps between +2.2 and -2.2 MHz
// [RL7] new channel clears fine offset
// [RL8] fine-down mirrors fine-up, lowering frequency
// [RL9] edit on: channel-up steps, repeats every 600 ms
// [RL10] edit off: step until skip memory stop data
// [RL11] auto search stops on station, pause 600 ms
// [RL12] channel-down mirrors channel-up, going lower
// [RL13] loudness steps every 100 ms, 64 duty levels
// [RL14] chroma and hue step like loudness
// [RL15] edit on: skip-erase writes 1, mutes
// [RL16] edit on: skip-write writes 0, mutes
// [RL17] audio mux key advances selector sequence
// [RL18] power key toggles; off ignores other keys
// [RL19] band switch picks plan, toggle resets channel 2
// [RL20] auto-tune switch follows correction inputs, no fine keys
// [RL21] channel lock ignores digits and up/down
// [RL22] edit switch gates loudness, mux, skip keys
// [RL23] count diode: fitted 133, open 105 channels
// [RL24] fitted diode reads one, open reads zero
// [RL25] station detector answers within 100 ms
// [RL26] scan one row, sample returns, debounce
module tkmc_key_matrix #(
    parameter int TICK_CYCLES = tkmc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // key matrix
    output logic [6:0] row_drive,
    output logic [1:0] digit_drive,
    input wire logic [3:0] return_in,
    // external status inputs
    input wire logic station_detect_n,
    input wire logic skip_data_in,
    input wire logic auto_up_in,
    input wire logic auto_down_in,
    // tuning
    output logic [6:0] channel_num,
    output logic [6:0] fine_offset,
    output logic picture_mute,
    // skip memory write
    output logic skip_write_strobe,
    output logic skip_write_bit,
    // levels and duty outputs
    output tkmc_pkg::tkmc_levels_s levels,
    output logic loudness_pwm,
    output logic chroma_pwm,
    output logic hue_pwm,
    // audio, power, display
    output logic audio_mux_sel_1,
    output logic audio_mux_sel_2,
    output logic power_on,
    output logic mute,
    output logic display_blank,
    output logic entry_pending,
    output logic [3:0] entry_tens
);
    import tkmc_pkg::*;

    tkmc_state_s s;
    tkmc_state_s next_s;

    logic ms;
    logic frame;
    logic act;
    logic [35:0] press;
    logic [35:0] cur;
    logic [8:0] rows;
    logic [4:0] dig;
    logic [6:0] num;
    logic [6:0] top;
    logic fine_due;
    logic lvl_due;
    logic step_ch;
    logic ch_key;

    function automatic logic [6:0] fine_step(input logic [6:0] f,
                                             input logic up);
        if (up) begin
            fine_step = (f == FINE_UPPER) ? FINE_LOWER : f + 7'h01;
        end else begin
            fine_step = (f == FINE_LOWER) ? FINE_UPPER : f - 7'h01;
        end
    endfunction

    function automatic logic [5:0] lvl_step(input logic [5:0] l,
                                            input logic up);
        if (up) begin
            lvl_step = (l == LEVEL_MAX) ? l : l + 6'h01;
        end else begin
            lvl_step = (l == 6'h00) ? l : l - 6'h01;
        end
    endfunction

    function automatic logic [6:0] next_channel(input logic [6:0] c,
                                                input logic up,
                                                input logic [6:0] t);
        if (up) begin
            next_channel = (c >= t) ? CH_MIN : c + 7'h01;
        end else begin
            next_channel = (c <= CH_MIN) ? t : c - 7'h01;
        end
    endfunction

    function automatic logic [4:0] first_digit(input logic [9:0] p);
        first_digit = 5'h00;
        for (int i = 9; i >= 0; i--) begin
            if (p[i]) begin
                first_digit = {1'b1, 4'(i)};
            end
        end
    endfunction

    function automatic logic pwm_level(input logic [6:0] cnt,
                                       input logic [5:0] l);
        // level 0 is 0/67, level n is (n+2)/67
        pwm_level = (l != 6'h00) && (cnt < ({1'b0, l} + PWM_OFFSET));
    endfunction

    always_comb begin
        next_s = s;
        next_s.skip_we = 1'b0;
        press = 36'h0_0000_0000;
        cur = s.raw;
        rows = 9'h000;
        dig = 5'h00;
        num = 7'h00;
        fine_due = 1'b0;
        lvl_due = 1'b0;
        step_ch = 1'b0;
        ch_key = 1'b0;
        frame = 1'b0;
        act = s.power;

        // synchronisers
        next_s.ret_s1 = return_in;
        next_s.ret_s2 = s.ret_s1;
        next_s.sd_s1 = station_detect_n;
        next_s.sd_s2 = s.sd_s1;
        next_s.sk_s1 = skip_data_in;
        next_s.sk_s2 = s.sk_s1;
        next_s.au_s1 = auto_up_in;
        next_s.au_s2 = s.au_s1;
        next_s.ad_s1 = auto_down_in;
        next_s.ad_s2 = s.ad_s1;

        // 1 ms tick divider
        ms = (s.tick_cnt == 18'(TICK_CYCLES - 1));
        next_s.tick_cnt = ms ? 18'h0_0000 : s.tick_cnt + 18'h0_0001;

        // row scan: sample at the end of each row period
        if (ms) begin
            cur[6'(s.row) * 6'd4 +: 4] = {s.ret_s2[0], s.ret_s2[1],
                                          s.ret_s2[2], s.ret_s2[3]}; // see [RL24]
            next_s.raw = cur;
            if (s.row == LAST_ROW) begin
                next_s.row = 4'h0;
                frame = 1'b1;
            end else begin
                next_s.row = s.row + 4'h1;
            end
            rows = 9'h001 << next_s.row; // see [RL26]
            next_s.row_drive = rows[6:0];
            next_s.digit_drive = rows[8:7];
        end

        // two equal frames in a row make the debounced image
        if (frame) begin
            next_s.prev = cur;
            if (cur == s.prev) begin
                next_s.deb = cur; // see [RL26]
            end
            press = next_s.deb & ~s.deb;
        end

        top = !s.deb[SW_CABLE] ? CH_BROADCAST_MAX :
              s.deb[DIODE_CH_COUNT] ? CH_CABLE_133_MAX :
              CH_CABLE_105_MAX; // see [RL19] [RL23]

        // power key
        if (press[KEY_POWER]) begin
            next_s.power = ~s.power; // see [RL18]
            next_s.blank = s.power;
            next_s.pending = 1'b0;
            next_s.ch_st = CH_IDLE;
            next_s.pic_mute = 1'b0;
            if (!s.power) begin
                next_s.mute = 1'b0;
            end
            act = 1'b0;
        end

        // band switch toggle
        if (act && frame && (next_s.deb[SW_CABLE] != s.deb[SW_CABLE])) begin
            next_s.channel = CH_MIN; // see [RL19]
            next_s.fine = 7'h00;
            next_s.pending = 1'b0;
            next_s.ch_st = CH_IDLE;
            next_s.pic_mute = 1'b0;
            act = 1'b0;
        end

        // direct entry
        dig = first_digit(press[9:0]);
        if (act && !s.deb[SW_CH_LOCK] && dig[4]) begin // see [RL21]
            if (s.pending) begin
                num = 7'(s.tens) * 7'd10 + 7'(dig[3:0]); // see [RL1]
                next_s.pending = 1'b0;
                if (num >= CH_MIN && num <= top) begin // see [RL3]
                    if (num != s.channel) begin
                        next_s.fine = 7'h00; // see [RL7]
                    end
                    next_s.channel = num;
                end
            end else begin
                next_s.pending = 1'b1;
                next_s.tens = dig[3:0];
                next_s.entry_tmr = 12'h000;
            end
        end else if (s.pending && ms) begin
            if (s.entry_tmr == 12'(ENTRY_CNT - 1)) begin
                next_s.pending = 1'b0; // see [RL2]
            end else begin
                next_s.entry_tmr = s.entry_tmr + 12'h001;
            end
        end

        // shared repeat timer for fine and level keys
        if (ms) begin
            fine_due = (s.deb[KEY_FINE_UP] || s.deb[KEY_FINE_DOWN]) &&
                       (s.rep_tmr == 10'(FINE_HOLD_CNT - 1));
            lvl_due = (s.rep_tmr == 10'(LEVEL_REPEAT_CNT - 1));
            if (fine_due) begin
                next_s.rep_tmr = 10'(FINE_HOLD_CNT - FINE_REPEAT_CNT); // see [RL5]
            end else if (lvl_due && !(s.deb[KEY_FINE_UP] ||
                                      s.deb[KEY_FINE_DOWN])) begin
                next_s.rep_tmr = 10'h000; // see [RL13]
            end else begin
                next_s.rep_tmr = s.rep_tmr + 10'h001;
            end
        end
        if (|press[KEY_HUE_DOWN:KEY_FINE_UP]) begin
            next_s.rep_tmr = 10'h000;
        end

        // manual fine tuning, disabled in auto-tune mode
        if (act && !s.deb[SW_AUTO_TUNE]) begin // see [RL20]
            if (press[KEY_FINE_UP] || (fine_due && s.deb[KEY_FINE_UP])) begin
                next_s.fine = fine_step(s.fine, 1'b1); // see [RL4] [RL6]
            end else if (press[KEY_FINE_DOWN] ||
                         (fine_due && s.deb[KEY_FINE_DOWN])) begin
                next_s.fine = fine_step(s.fine, 1'b0); // see [RL8]
            end
        end

        // automatic correction every 8 ms, idle during channel stepping
        if (act && s.deb[SW_AUTO_TUNE] && s.ch_st == CH_IDLE && ms) begin
            if (s.auto_tmr == 4'(AUTO_CNT - 1)) begin
                next_s.auto_tmr = 4'h0;
                if (s.au_s2 && !s.ad_s2) begin
                    next_s.fine = fine_step(s.fine, 1'b1); // see [RL20]
                end else if (s.ad_s2 && !s.au_s2) begin
                    next_s.fine = fine_step(s.fine, 1'b0);
                end
            end else begin
                next_s.auto_tmr = s.auto_tmr + 4'h1;
            end
        end

        // level keys; loudness is locked out while editing skip memory
        if (act && !s.deb[SW_MEM_EDIT]) begin // see [RL22]
            if (press[KEY_LOUD_UP] || (lvl_due && s.deb[KEY_LOUD_UP])) begin
                next_s.lvl.loudness = lvl_step(s.lvl.loudness, 1'b1); // see [RL13]
            end else if (press[KEY_LOUD_DOWN] ||
                         (lvl_due && s.deb[KEY_LOUD_DOWN])) begin
                next_s.lvl.loudness = lvl_step(s.lvl.loudness, 1'b0);
            end
        end
        if (act) begin
            if (press[KEY_CHROMA_UP] || (lvl_due && s.deb[KEY_CHROMA_UP])) begin
                next_s.lvl.chroma = lvl_step(s.lvl.chroma, 1'b1); // see [RL14]
            end else if (press[KEY_CHROMA_DOWN] ||
                         (lvl_due && s.deb[KEY_CHROMA_DOWN])) begin
                next_s.lvl.chroma = lvl_step(s.lvl.chroma, 1'b0);
            end
            if (press[KEY_HUE_UP] || (lvl_due && s.deb[KEY_HUE_UP])) begin
                next_s.lvl.hue = lvl_step(s.lvl.hue, 1'b1); // see [RL14]
            end else if (press[KEY_HUE_DOWN] ||
                         (lvl_due && s.deb[KEY_HUE_DOWN])) begin
                next_s.lvl.hue = lvl_step(s.lvl.hue, 1'b0);
            end
        end

        // skip memory edit and audio multiplex
        if (act && s.deb[SW_MEM_EDIT]) begin // see [RL22]
            if (press[KEY_SKIP_ERASE]) begin
                next_s.skip_we = 1'b1; // see [RL15]
                next_s.skip_bit = 1'b1;
                next_s.mute = 1'b1;
            end else if (press[KEY_SKIP_WRITE]) begin
                next_s.skip_we = 1'b1; // see [RL16]
                next_s.skip_bit = 1'b0;
                next_s.mute = 1'b1;
            end
        end else if (act && press[KEY_AUDIO_MUX]) begin
            next_s.mux = {~s.mux[1] | s.mux[0], ~(&s.mux)}; // see [RL17]
        end

        // channel up/down
        ch_key = s.ch_up ? s.deb[KEY_CH_UP] : s.deb[KEY_CH_DOWN];
        if (act && !s.deb[SW_CH_LOCK] && s.ch_st == CH_IDLE &&
            (press[KEY_CH_UP] || press[KEY_CH_DOWN])) begin // see [RL21]
            next_s.ch_up = press[KEY_CH_UP]; // see [RL12]
            step_ch = 1'b1;
        end else if (act) begin
            unique case (s.ch_st)
                CH_IDLE: begin
                end
                CH_SKIP: begin
                    if (ms) begin
                        next_s.ch_tmr = s.ch_tmr + 10'h001;
                        if (s.ch_tmr == 10'(SETTLE_CNT - 1)) begin
                            if (!s.sk_s2) begin
                                next_s.ch_st = CH_PAUSE; // see [RL10]
                                next_s.ch_tmr = 10'h000;
                            end else begin
                                step_ch = 1'b1;
                            end
                        end
                    end
                end
                CH_SEARCH: begin
                    if (!s.sd_s2) begin
                        next_s.ch_st = CH_PAUSE; // see [RL11] [RL25]
                        next_s.ch_tmr = 10'h000;
                    end else if (ms) begin
                        next_s.ch_tmr = s.ch_tmr + 10'h001;
                        if (s.ch_tmr == 10'(SEARCH_CNT - 1)) begin
                            step_ch = 1'b1;
                        end
                    end
                end
                CH_PAUSE: begin
                    if (!ch_key) begin
                        next_s.ch_st = CH_IDLE;
                    end else if (ms) begin
                        next_s.ch_tmr = s.ch_tmr + 10'h001;
                        if (s.ch_tmr == 10'(PAUSE_CNT - 1)) begin
                            step_ch = 1'b1; // see [RL9]
                        end
                    end
                end
            endcase
        end
        if (step_ch) begin
            next_s.channel = next_channel(s.channel, next_s.ch_up, top);
            next_s.fine = 7'h00; // see [RL7]
            next_s.ch_tmr = 10'h000;
            next_s.pending = 1'b0;
            if (s.deb[DIODE_UPDOWN]) begin
                next_s.ch_st = CH_SEARCH; // see [RL11]
            end else if (s.deb[SW_MEM_EDIT]) begin
                next_s.ch_st = CH_PAUSE; // see [RL9]
            end else begin
                next_s.ch_st = CH_SKIP; // see [RL10]
            end
        end
        next_s.pic_mute = act && (next_s.ch_st == CH_SEARCH ||
                                  next_s.ch_st == CH_SKIP);

        // duty outputs over a 67-count period
        next_s.pwm_cnt = (s.pwm_cnt == PWM_PERIOD - 7'h01) ? 7'h00 :
                         s.pwm_cnt + 7'h01;
        next_s.pwm_loud = pwm_level(s.pwm_cnt, s.lvl.loudness); // see [RL13]
        next_s.pwm_chroma = pwm_level(s.pwm_cnt, s.lvl.chroma);
        next_s.pwm_hue = pwm_level(s.pwm_cnt, s.lvl.hue);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.channel <= CH_MIN;
            s.lvl <= {LEVEL_INIT, LEVEL_INIT, LEVEL_INIT};
            s.mux <= MUX_INIT;
            s.blank <= 1'b1;
            s.ch_st <= CH_IDLE;
            s.ret_s1 <= 4'h0;
            s.row_drive <= 7'h01;
            s.sd_s1 <= 1'b1;
            s.sd_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign row_drive = s.row_drive;
    assign digit_drive = s.digit_drive;
    assign channel_num = s.channel;
    assign fine_offset = s.fine;
    assign picture_mute = s.pic_mute;
    assign skip_write_strobe = s.skip_we;
    assign skip_write_bit = s.skip_bit;
    assign levels = s.lvl;
    assign loudness_pwm = s.pwm_loud;
    assign chroma_pwm = s.pwm_chroma;
    assign hue_pwm = s.pwm_hue;
    assign audio_mux_sel_1 = s.mux[1];
    assign audio_mux_sel_2 = s.mux[0];
    assign power_on = s.power;
    assign mute = s.mute;
    assign display_blank = s.blank;
    assign entry_pending = s.pending;
    assign entry_tens = s.tens;
endmodule

// ### tkmc_key_matrix_monitor.sv
/* port checker of the key matrix controller
   bound into every tkmc_key_matrix, one clock domain */
`timescale 1ns/10ps
module tkmc_key_matrix_monitor (
    // watched ports
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [6:0] row_drive,
    input wire logic [1:0] digit_drive,
    input wire logic [6:0] channel_num,
    input wire logic [6:0] fine_offset,
    input wire logic skip_write_strobe,
    input wire logic audio_mux_sel_1,
    input wire logic audio_mux_sel_2,
    input wire logic power_on,
    input wire logic mute,
    input wire logic display_blank
);
    import tkmc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_row; $onehot({digit_drive, row_drive}); endproperty
    a_row: assert property (p_row) else $error("rows not one-hot");
    property p_hold;
        $changed(row_drive) |=> $stable(row_drive) [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("row too short");
    property p_blank; display_blank == !power_on; endproperty
    a_blank: assert property (p_blank) else $error("blank wrong");
    property p_fine;
        $signed(fine_offset) <= 55 && $signed(fine_offset) >= -55;
    endproperty
    a_fine: assert property (p_fine) else $error("fine range");
    property p_chan;
        channel_num >= CH_MIN && channel_num <= CH_BROADCAST_MAX;
    endproperty
    a_chan: assert property (p_chan) else $error("channel range");
    property p_strobe; skip_write_strobe |=> !skip_write_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("long strobe");
    property p_mute; skip_write_strobe |-> ##[0:1] mute; endproperty
    a_mute: assert property (p_mute) else $error("no mute");
    property p_mux; {audio_mux_sel_1, audio_mux_sel_2} != 2'b00; endproperty
    a_mux: assert property (p_mux) else $error("mux state");
endmodule
bind tkmc_key_matrix tkmc_key_matrix_monitor i_mon (.clk(clk),
    .arst_n(arst_n), .row_drive(row_drive), .digit_drive(digit_drive),
    .channel_num(channel_num), .fine_offset(fine_offset),
    .skip_write_strobe(skip_write_strobe),
    .audio_mux_sel_1(audio_mux_sel_1), .audio_mux_sel_2(audio_mux_sel_2),
    .power_on(power_on), .mute(mute), .display_blank(display_blank));

// ### tkmc_panel_model.sv
/* front-panel keys, switches and diodes
   closed contact ties scanned row to its return */
`timescale 1ns/10ps
module tkmc_panel_model (
    // scan and contacts
    input wire logic [8:0] rows,
    input wire logic [35:0] closed,
    // returns
    output logic [3:0] return_in
);
    import tkmc_pkg::*;
    always_comb begin
        return_in = 4'h0; // open returns pulled low
        for (int r = 0; r < 9; r++) begin
            for (int k = 0; k < 4; k++) begin
                if (rows[r] && closed[r * 4 + 3 - k]) begin
                    return_in[k] = 1'b1;
                end
            end
        end
    end
endmodule

// ### tb_top.sv
/* self-checking bench of the key matrix controller
   tick shortened to 20 clocks, key waits of three frames */
`timescale 1ns/10ps
module tb_top;
    import tkmc_pkg::*;
    localparam int TC = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [35:0] keys = '0;
    logic [3:0] ret;
    logic [6:0] rd, ch, fo, cur;
    logic [1:0] dd;
    logic ws, wb, pm, mt, pw, bl, m1, m2, sdn, skd, lpwm;
    logic [1:0] mux_seq [3] = '{2'b10, 2'b01, 2'b11};
    tkmc_levels_s lv;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'hfd85;
    int t, u, lp;
    always #2.5 clk = ~clk;
    assign sdn = ch != 7'd24;
    assign skd = ch == 7'd21;
    tkmc_panel_model i_panel (.rows({dd, rd}), .closed(keys), .return_in(ret));
    tkmc_key_matrix #(.TICK_CYCLES(TC)) i_dut (
        .clk(clk), .arst_n(arst_n), .row_drive(rd), .digit_drive(dd),
        .return_in(ret), .station_detect_n(sdn), .skip_data_in(skd),
        .auto_up_in(1'b0), .auto_down_in(1'b0), .channel_num(ch),
        .fine_offset(fo), .picture_mute(pm), .skip_write_strobe(ws),
        .skip_write_bit(wb), .levels(lv), .loudness_pwm(lpwm), .chroma_pwm(),
        .hue_pwm(), .audio_mux_sel_1(m1), .audio_mux_sel_2(m2),
        .power_on(pw), .mute(mt), .display_blank(bl), .entry_pending(),
        .entry_tens());
    task chk(input string n, input logic [17:0] e, input logic [17:0] s);
        tests_run++;
        if (e !== s) begin
            $display("MISMATCH %s exp %h got %h", n, e, s);
            miscompares++;
        end
    endtask
    task sw(input int k, input logic v);
        @(posedge clk);
        keys[k] <= v;
        repeat (27 * TC) @(posedge clk);
    endtask
    task press(input int k);
        sw(k, 1'b1);
        sw(k, 1'b0);
    endtask
    function automatic logic [6:0] exp_ch(input int a, b, top);
        int n;
        n = a * 10 + b;
        return (n >= 2 && n <= top) ? 7'(n) : cur;
    endfunction
    task ent(input int a, input int b, input int top);
        press(a);
        press(b);
        cur = exp_ch(a, b, top);
        chk("channel", 18'(cur), 18'(ch));
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        cur = CH_MIN;
        chk("reset", 18'({ch, fo, m1, m2, pw, bl}), 18'({CH_MIN, 11'h0d}));
        chk("levels", {3{LEVEL_INIT}}, lv);
        press(KEY_POWER);
        chk("power", 18'(2'b10), 18'({pw, bl}));
        ent(1, 2, 83);
        ent(9, 9, 83);
        press(KEY_FINE_UP);
        chk("fine", 18'(7'h01), 18'(fo));
        press(KEY_FINE_DOWN);
        press(KEY_FINE_DOWN);
        chk("fine", 18'(7'h7f), 18'(fo));
        sw(SW_AUTO_TUNE, 1'b1);
        press(KEY_FINE_UP);
        chk("fine", 18'(7'h7f), 18'(fo));
        sw(SW_AUTO_TUNE, 1'b0);
        ent(1, 3, 83);
        chk("fine", 18'(7'h00), 18'(fo));
        sw(KEY_FINE_UP, 1'b1);
        repeat (690 * TC) @(posedge clk);
        sw(KEY_FINE_UP, 1'b0);
        chk("hold", 18'(7'h03), 18'(fo));
        repeat (3) begin
            t = {$random(seed)} % 9;
            u = {$random(seed)} % 10;
            ent(t, u, 83);
        end
        press(KEY_LOUD_UP);
        chk("loud", 18'(6'h21), 18'(lv.loudness));
        lp = 0;
        repeat (67) @(posedge clk) lp += lpwm;
        chk("duty", 18'(7'h23), 18'(lp));
        press(KEY_CHROMA_DOWN);
        press(KEY_HUE_UP);
        chk("levels", {6'h21, 6'h1f, 6'h21}, lv);
        for (int i = 0; i < 3; i++) begin
            press(KEY_AUDIO_MUX);
            chk("mux", 18'(mux_seq[i]), 18'({m1, m2}));
        end
        ent(2, 0, 83);
        sw(SW_MEM_EDIT, 1'b1);
        press(KEY_LOUD_UP);
        press(KEY_AUDIO_MUX);
        chk("gated", 18'({6'h21, 2'b11}), 18'({lv.loudness, m1, m2}));
        press(KEY_SKIP_ERASE);
        chk("erase", 18'(2'b11), 18'({wb, mt}));
        press(KEY_SKIP_WRITE);
        chk("write", 18'(2'b01), 18'({wb, mt}));
        press(KEY_CH_UP);
        chk("up", 18'(7'd21), 18'(ch));
        press(KEY_CH_DOWN);
        chk("down", 18'(7'd20), 18'(ch));
        sw(SW_MEM_EDIT, 1'b0);
        press(KEY_CH_UP);
        chk("skip", 18'(7'd22), 18'(ch));
        sw(SW_CH_LOCK, 1'b1);
        press(3);
        press(5);
        press(KEY_CH_UP);
        chk("lock", 18'(7'd22), 18'(ch));
        sw(SW_CH_LOCK, 1'b0);
        sw(DIODE_UPDOWN, 1'b1);
        press(KEY_CH_UP);
        chk("search", 18'({7'd23, 1'b1}), 18'({ch, pm}));
        repeat (100 * TC) @(posedge clk);
        chk("found", 18'({7'd24, 1'b0}), 18'({ch, pm}));
        sw(SW_CABLE, 1'b1);
        cur = CH_MIN;
        chk("band", 18'(CH_MIN), 18'(ch));
        ent(4, 0, 36);
        ent(3, 6, 36);
        sw(DIODE_CH_COUNT, 1'b1);
        ent(6, 4, 64);
        press(KEY_POWER);
        press(KEY_LOUD_UP);
        chk("off", 18'({6'h21, 2'b01}), 18'({lv.loudness, pw, bl}));
        press(KEY_POWER);
        chk("on", 18'({7'd64, 2'b10}), 18'({ch, pw, mt}));
        summarize;
    end
endmodule
